// [rtl/sicp_pkg.sv]
// Purpose: Shared constants for the serial configuration port.
// Assumes: System clock 125 MHz; serial lines sampled by that clock.
// Notes: Register indexes are byte locations on the serial bus.
package sicp_pkg;
    localparam logic [6:0] WRITE_ADDR7 = 7'h6E;
    localparam logic [7:0] WRITE_ADDR_BYTE = 8'hDC;
    localparam logic [7:0] READ_ADDR_BYTE = 8'hDD;
    localparam logic [7:0] IDX_CONFIG = 8'h00;
    localparam logic [7:0] IDX_BYTE_COUNT = 8'h06;
    localparam logic [7:0] CONFIG_RESET = 8'h07;
    localparam logic [7:0] CONFIG_WRITE_MASK = 8'hC7;
    localparam logic [7:0] BYTE_COUNT_RESET = 8'h07;
    localparam int BIT_PD_FLOAT = 7;
    localparam int BIT_STOP_FLOAT = 6;
    localparam int BIT_LOW_BW = 2;
    localparam int BIT_ZDB = 1;
    localparam int BIT_UNDIVIDED = 0;
    localparam int SYNC_STAGES = 2;
endpackage

// [rtl/sicp_line_if.sv]
// Purpose: Carries conditioned serial bus events between modules.
// Assumes: All signals are on the system clock.
// Notes: Pulses last one clock.
`timescale 1ns/1ps
`default_nettype none
interface sicp_line_if;
    logic start_seen;
    logic stop_seen;
    logic scl_rise;
    logic scl_fall;
    logic sda_level;
    modport source (output start_seen, stop_seen, scl_rise, scl_fall,
        sda_level);
    modport sink (input start_seen, stop_seen, scl_rise, scl_fall,
        sda_level);
endinterface
`default_nettype wire

// [rtl/sicp_line_sync.sv]
// Purpose: Synchronises the serial lines and finds edges and conditions.
// Assumes: Serial clock much slower than the system clock.
// Notes: Only second-stage values feed the edge logic.
`timescale 1ns/1ps
`default_nettype none
module sicp_line_sync (
    input wire logic clk,       // System clock.
    input wire logic reset_n,   // Synchronous reset, active low.
    input wire logic scl_in,    // Serial clock pin level.
    input wire logic sda_in,    // Serial data pin level.
    sicp_line_if.source ev      // Conditioned events.
);
    logic [1:0] scl_sync_q;
    logic [1:0] sda_sync_q;
    logic scl_prev_q;
    logic sda_prev_q;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_sync_q <= {scl_sync_q[0], scl_in};
            sda_sync_q <= {sda_sync_q[0], sda_in};
            scl_prev_q <= scl_sync_q[1];
            sda_prev_q <= sda_sync_q[1];
        end
    end

    assign ev.scl_rise = scl_sync_q[1] && !scl_prev_q;
    assign ev.scl_fall = !scl_sync_q[1] && scl_prev_q;
    assign ev.start_seen = scl_sync_q[1] && scl_prev_q && sda_prev_q &&
        !sda_sync_q[1];
    assign ev.stop_seen = scl_sync_q[1] && scl_prev_q && !sda_prev_q &&
        sda_sync_q[1];
    assign ev.sda_level = sda_sync_q[1];
endmodule
`default_nettype wire

// [rtl/sicp_port.sv]
// Purpose: Indexed block read and write slave with configuration byte.
// Assumes: Host keeps the serial protocol; lines are open drain.
// Notes: Only the configuration and byte-count bytes are stored.
`timescale 1ns/1ps
`default_nettype none
module sicp_port (
    input wire logic clk,                  // System clock, 125 MHz.
    input wire logic reset_n,              // Synchronous reset, low.
    input wire logic scl_in,               // Serial clock pin.
    input wire logic sda_in,               // Serial data pin level.
    output logic sda_out,                  // Data drive value, always 0.
    output logic sda_oe,                   // High pulls data line low.
    output logic powerdown_float_select,   // Float outputs in power-down.
    output logic stop_float_select,        // Float outputs when halted.
    output logic loop_bandwidth_select,    // 1 selects low bandwidth.
    output logic zero_delay_buffer_mode,   // 1 selects zero-delay mode.
    output logic input_halve_select        // 1 passes input undivided.
);
    typedef enum {
        SICP_IDLE, SICP_ADDR, SICP_ADDR_ACK, SICP_INDEX, SICP_INDEX_ACK,
        SICP_COUNT, SICP_COUNT_ACK, SICP_WDATA, SICP_WDATA_ACK,
        SICP_RDATA, SICP_RACK, SICP_IGNORE
    } sicp_state_t;

    sicp_line_if ev ();
    sicp_state_t state_q;
    logic [7:0] shift_q;
    logic [2:0] bit_q;
    logic [7:0] index_q;
    logic [7:0] left_q;
    logic [7:0] config_q;
    logic [7:0] byte_count_q;
    logic reading_q;
    logic count_sent_q;
    logic drive_q;
    logic [7:0] rd_byte;
    logic [7:0] next_shift;

    sicp_line_sync u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .ev(ev)
    );

    assign next_shift = {shift_q[6:0], ev.sda_level};

    always_comb begin
        rd_byte = 8'h00;
        if (index_q == sicp_pkg::IDX_CONFIG) begin
            rd_byte = config_q;
        end else if (index_q == sicp_pkg::IDX_BYTE_COUNT) begin
            rd_byte = byte_count_q;
        end
    end

    // ------------------------------------------------------------------
    // Protocol sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q <= SICP_IDLE;
            shift_q <= 8'h00;
            bit_q <= 3'h0;
            index_q <= 8'h00;
            left_q <= 8'h00;
            reading_q <= 1'b0;
            count_sent_q <= 1'b0;
        end else if (ev.stop_seen) begin
            state_q <= SICP_IDLE;
        end else if (ev.start_seen) begin
            // A repeated start keeps the stored index for the read.
            state_q <= SICP_ADDR;
            bit_q <= 3'h0;
        end else begin
            unique case (state_q)
                SICP_IDLE, SICP_IGNORE: begin
                end
                SICP_ADDR, SICP_INDEX, SICP_COUNT, SICP_WDATA: begin
                    if (ev.scl_rise) begin
                        shift_q <= next_shift;
                        bit_q <= bit_q + 3'h1;
                    end
                    if (ev.scl_rise && bit_q == 3'h7) begin
                        unique case (state_q)
                            SICP_ADDR: begin
                                if (next_shift ==
                                    sicp_pkg::WRITE_ADDR_BYTE) begin
                                    reading_q <= 1'b0;
                                    state_q <= SICP_ADDR_ACK;
                                end else if (next_shift ==
                                    sicp_pkg::READ_ADDR_BYTE) begin
                                    reading_q <= 1'b1;
                                    count_sent_q <= 1'b0;
                                    left_q <= byte_count_q;
                                    state_q <= SICP_ADDR_ACK;
                                end else begin
                                    state_q <= SICP_IGNORE;
                                end
                            end
                            SICP_INDEX: begin
                                index_q <= next_shift;
                                state_q <= SICP_INDEX_ACK;
                            end
                            SICP_COUNT: begin
                                left_q <= next_shift;
                                state_q <= SICP_COUNT_ACK;
                            end
                            default: begin
                                state_q <= SICP_WDATA_ACK;
                            end
                        endcase
                    end
                end
                SICP_ADDR_ACK, SICP_INDEX_ACK, SICP_COUNT_ACK,
                SICP_WDATA_ACK: begin
                    // Acknowledge ends on the falling edge after the ninth.
                    if (ev.scl_fall && drive_q) begin
                        bit_q <= 3'h0;
                        unique case (state_q)
                            SICP_ADDR_ACK: begin
                                if (reading_q) begin
                                    shift_q <= left_q;
                                    state_q <= SICP_RDATA;
                                end else begin
                                    state_q <= SICP_INDEX;
                                end
                            end
                            SICP_INDEX_ACK: state_q <= SICP_COUNT;
                            SICP_COUNT_ACK: begin
                                state_q <= (left_q == 8'h00) ?
                                    SICP_IGNORE : SICP_WDATA;
                            end
                            default: begin
                                index_q <= index_q + 8'h01;
                                left_q <= left_q - 8'h01;
                                state_q <= (left_q == 8'h01) ?
                                    SICP_IGNORE : SICP_WDATA;
                            end
                        endcase
                    end
                end
                SICP_RDATA: begin
                    if (ev.scl_fall && bit_q == 3'h0) begin
                        shift_q <= rd_byte;
                    end else if (ev.scl_fall) begin
                        shift_q <= {shift_q[6:0], 1'b0};
                    end
                    if (ev.scl_rise) begin
                        bit_q <= bit_q + 3'h1;
                        if (bit_q == 3'h7) begin
                            state_q <= SICP_RACK;
                        end
                    end
                end
                SICP_RACK: begin
                    if (ev.scl_rise) begin
                        if (ev.sda_level) begin
                            state_q <= SICP_IGNORE;
                        end else begin
                            state_q <= SICP_RDATA;
                            bit_q <= 3'h0;
                            if (count_sent_q) begin
                                index_q <= index_q + 8'h01;
                            end
                            count_sent_q <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Data line drive
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            drive_q <= 1'b0;
        end else if (ev.start_seen || ev.stop_seen) begin
            drive_q <= 1'b0;
        end else if (ev.scl_fall) begin
            unique case (state_q)
                SICP_ADDR_ACK, SICP_INDEX_ACK, SICP_COUNT_ACK,
                SICP_WDATA_ACK: begin
                    // count follows acknowledge
                    // The count's first bit replaces the acknowledge at
                    // once; releasing here would lose that bit.
                    if (state_q == SICP_ADDR_ACK && reading_q && drive_q) begin
                        drive_q <= !left_q[7];
                    end else begin
                        drive_q <= !drive_q;
                    end
                end
                SICP_RDATA: begin
                    if (bit_q == 3'h0) begin
                        drive_q <= !rd_byte[7];
                    end else begin
                        drive_q <= !shift_q[6];
                    end
                end
                default: drive_q <= 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Stored registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            config_q <= sicp_pkg::CONFIG_RESET;
            byte_count_q <= sicp_pkg::BYTE_COUNT_RESET;
        end else if (state_q == SICP_WDATA && ev.scl_rise &&
            bit_q == 3'h7 && !ev.start_seen && !ev.stop_seen) begin
            if (index_q == sicp_pkg::IDX_CONFIG) begin
                config_q <= next_shift & sicp_pkg::CONFIG_WRITE_MASK;
            end else if (index_q == sicp_pkg::IDX_BYTE_COUNT) begin
                byte_count_q <= next_shift;
            end
        end
    end

    assign powerdown_float_select = config_q[sicp_pkg::BIT_PD_FLOAT];
    assign stop_float_select = config_q[sicp_pkg::BIT_STOP_FLOAT];
    assign loop_bandwidth_select = config_q[sicp_pkg::BIT_LOW_BW];
    assign zero_delay_buffer_mode = config_q[sicp_pkg::BIT_ZDB];
    assign input_halve_select = config_q[sicp_pkg::BIT_UNDIVIDED];
    assign sda_out = 1'b0;
    assign sda_oe = drive_q;
endmodule
`default_nettype wire

// [verif/sicp_port_properties.sv]
// Purpose: Bus-side properties of the configuration port.
// Assumes: Host keeps a bit time of 125 ns or more on the serial clock.
// Notes: Bound to every sicp_port instance.
`timescale 1ns/1ps
`default_nettype none
module sicp_port_properties (
    input wire logic clk, // System clock.
    input wire logic reset_n, // Reset, active low.
    input wire logic scl_in, // Serial clock line.
    input wire logic sda_in, // Data line level.
    input wire logic sda_out, // Data drive value.
    input wire logic sda_oe, // Data drive enable.
    input wire logic powerdown_float_select, // Config bit 7.
    input wire logic stop_float_select, // Config bit 6.
    input wire logic loop_bandwidth_select, // Config bit 2.
    input wire logic zero_delay_buffer_mode, // Config bit 1.
    input wire logic input_halve_select // Config bit 0.
);
    logic [4:0] cfg;
    logic [4:0] high_q;
    assign cfg = {powerdown_float_select, stop_float_select,
        loop_bandwidth_select, zero_delay_buffer_mode, input_halve_select};
    // A bit's high phase is under 9 cycles, so 16 means the bus is idle.
    always_ff @(posedge clk) begin
        if (!reset_n || !scl_in) begin
            high_q <= 5'h00;
        end else if (high_q != 5'h1F) begin
            high_q <= high_q + 5'h01;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence oe_held;
        $stable(sda_oe) [*5];
    endsequence
    sequence cfg_held;
        $stable(cfg) [*4];
    endsequence
    a_reset_defaults: assert property (
        disable iff (1'b0) !reset_n |=> cfg == 5'h07 && !sda_oe)
        else $error("defaults wrong in reset");
    a_reset_release: assert property ($rose(reset_n) |-> cfg == 5'h07)
        else $error("config moved at reset release");
    a_drive_low_only: assert property (sda_oe |-> sda_out == 1'b0)
        else $error("data driven high");
    a_edge_on_low: assert property (
        $changed(sda_oe) |-> !scl_in && !$past(scl_in))
        else $error("drive changed near clock high");
    a_hold_high: assert property ($rose(scl_in) |=> oe_held)
        else $error("drive changed while clock high");
    a_idle_release: assert property (high_q >= 5'h10 |-> !sda_oe)
        else $error("data held low on idle bus");
    a_cfg_idle_stable: assert property (
        high_q >= 5'h10 |-> $stable(cfg))
        else $error("config moved on idle bus");
    a_cfg_single_step: assert property ($changed(cfg) |=> cfg_held)
        else $error("config changed twice at once");
endmodule
bind sicp_port sicp_port_properties chk_u (.clk(clk), .reset_n(reset_n),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .powerdown_float_select(powerdown_float_select),
    .stop_float_select(stop_float_select),
    .loop_bandwidth_select(loop_bandwidth_select),
    .zero_delay_buffer_mode(zero_delay_buffer_mode),
    .input_halve_select(input_halve_select));
`default_nettype wire

// [verif/sicp_host_model.sv]
// Purpose: Serial bus host that frames bytes for the port.
// Assumes: Data line is open drain with a pull-up outside.
// Notes: Clock stands high between frames; slow stretches low phases.
`timescale 1ns/1ps
`default_nettype none
module sicp_host_model (
    input wire logic sda_wire, // Resolved data line.
    output logic scl, // Serial clock.
    output logic sda_low // High pulls data low.
);
    localparam realtime Q = 31.25;
    int slow = 0;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic start_c();
        sda_low = 1'b0;
        #Q scl = 1'b1;
        #(2 * Q) sda_low = 1'b1;
        #(2 * Q) scl = 1'b0;
        #Q;
    endtask
    task automatic stop_c();
        sda_low = 1'b1;
        #Q scl = 1'b1;
        #Q sda_low = 1'b0;
        #(2 * Q);
    endtask
    task automatic bit_c(input logic b, output logic seen);
        sda_low = !b;
        #(Q * (1 + slow)) scl = 1'b1;
        #Q seen = sda_wire;
        #Q scl = 1'b0;
        #Q;
    endtask
    task automatic xfer(input logic [7:0] tx, input logic nine,
        output logic [7:0] rx, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_c(tx[i], s);
            rx[i] = s;
        end
        bit_c(nine, s);
        ack = !s;
    endtask
endmodule
`default_nettype wire

// [verif/sicp_port_tb.sv]
// Purpose: Self-checking bench for the configuration port.
// Assumes: Host model frames every transfer.
// Notes: Row table covers config values; odd cases follow it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
    fail_count++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module sicp_port_tb;
    typedef struct {logic [7:0] wr; logic [7:0] rb;} sicp_row_t;
    logic clk, reset_n, scl, host_low, sda, dut_out, dut_oe;
    wire [4:0] cfg;
    int fail_count = 0;
    int comparisons = 0;
    sicp_row_t rows[5] = '{'{8'hFF, 8'hC7}, '{8'h38, 8'h00},
        '{8'h81, 8'h81}, '{8'h46, 8'h46}, '{8'h00, 8'h00}};
    // Power-up read: count, config, five empty bytes, then the count.
    logic [7:0] reset_rd[$] = '{8'h07, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h07};
    logic [4:0] exp_cfg;
    assign sda = (host_low || dut_oe) ? 1'b0 : 1'b1;
    sicp_host_model host_u (.sda_wire(sda), .scl(scl), .sda_low(host_low));
    sicp_port dut_u (.clk(clk), .reset_n(reset_n), .scl_in(scl),
        .sda_in(sda), .sda_out(dut_out), .sda_oe(dut_oe),
        .powerdown_float_select(cfg[4]), .stop_float_select(cfg[3]),
        .loop_bandwidth_select(cfg[2]), .zero_delay_buffer_mode(cfg[1]),
        .input_halve_select(cfg[0]));
    task automatic summarize();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, idx, cnt, input logic [7:0] d[$]);
        logic [7:0] b[$];
        logic [7:0] rx;
        logic ak;
        logic exp_ak;
        b = {a, idx, cnt, d};
        host_u.start_c();
        foreach (b[k]) begin
            host_u.xfer(b[k], 1'b1, rx, ak);
            exp_ak = (a == sicp_pkg::WRITE_ADDR_BYTE) &&
                (k < 3 || k - 3 < int'(cnt));
            `CHK("ack", exp_ak, ak)
        end
        host_u.stop_c();
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] e[$]);
        logic [7:0] rx;
        logic ak;
        host_u.start_c();
        host_u.xfer(sicp_pkg::WRITE_ADDR_BYTE, 1'b1, rx, ak);
        `CHK("wr_ack", 1'b1, ak)
        host_u.xfer(idx, 1'b1, rx, ak);
        `CHK("idx_ack", 1'b1, ak)
        host_u.start_c();
        host_u.xfer(sicp_pkg::READ_ADDR_BYTE, 1'b1, rx, ak);
        `CHK("rd_ack", 1'b1, ak)
        foreach (e[k]) begin
            host_u.xfer(8'hFF, k == e.size() - 1, rx, ak);
            `CHK("rdata", e[k], rx)
        end
        host_u.stop_c();
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        #400_000;
        fail_count++;
        summarize();
    end
    // -------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------
    initial begin
        reset_n = 1'b0;
        repeat (6) @(posedge clk);
        #1 reset_n = 1'b1;
        repeat (4) @(posedge clk);
        `CHK("cfg", 5'h07, cfg)
        `CHK("sda_out", 1'b0, dut_out)
        rd(8'h00, reset_rd);
        wr(sicp_pkg::WRITE_ADDR_BYTE, 8'h06, 8'h01, '{8'h01});
        foreach (rows[i]) begin
            wr(sicp_pkg::WRITE_ADDR_BYTE, 8'h00, 8'h01, '{rows[i].wr});
            exp_cfg = {rows[i].rb[7:6], rows[i].rb[2:0]};
            `CHK("cfg", exp_cfg, cfg)
            rd(8'h00, '{8'h01, rows[i].rb});
        end
        host_u.slow = 3;
        wr(sicp_pkg::WRITE_ADDR_BYTE, 8'h06, 8'h01, '{8'h02});
        rd(8'h05, '{8'h02, 8'h00, 8'h02});
        host_u.slow = 0;
        wr(sicp_pkg::WRITE_ADDR_BYTE, 8'h00, 8'h01, '{8'h00, 8'hFF});
        `CHK("cfg", 5'h00, cfg)
        wr(8'hA0, 8'h00, 8'h01, '{8'hFF});
        `CHK("cfg", 5'h00, cfg)
        @(posedge clk);
        #1 reset_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 reset_n = 1'b1;
        repeat (4) @(posedge clk);
        `CHK("cfg", 5'h07, cfg)
        rd(8'h00, reset_rd);
        summarize();
    end
endmodule
`default_nettype wire
